// *** dv/tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb import ucz_pkg::*; ;
  typedef struct packed {logic [11:0] a; logic [31:0] v; logic e;} ucz_row_t;
  logic clk, rst_n, psel, penable, pwrite, pready, pslverr, er, got, d1;
  logic tokValid, rxValid, rxEnd, rxOk, hostAck, hsValid, irqPending;
  logic txValid, txLast, txZlp, txData1, txReady;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rv;
  logic [1:0] tokType, hsCode, hc;
  logic [6:0] tokAddr, function_address_reg;
  logic [3:0] tokEndp;
  logic [7:0] rxData, txData;
  logic [15:0] descPtr;
  logic [63:0] dq;
  int mismatches, n_compared, nb;
  ucz_row_t rows [7] = '{'{ADDR_CTRL, 32'h0000_0004, 1'b0},
    '{ADDR_IRQ_EN, 32'h0, 1'b0}, '{ADDR_IRQ_REQ, 32'h0, 1'b0},
    '{ADDR_BYTE_CNT, 32'h0, 1'b0}, '{ADDR_DESC_PTR, 32'h0, 1'b0},
    '{ADDR_FN_ADDR, 32'h0, 1'b0}, '{12'h018, 32'h0, 1'b1}};
  ucz_ep0 dut (.clk, .rst_n, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata,
    .pready, .pslverr, .tokValid, .tokType, .tokAddr, .tokEndp, .rxValid, .rxData,
    .rxEnd, .rxOk, .hostAck, .hsValid, .hsCode, .txValid, .txData, .txLast, .txZlp,
    .txData1, .txReady, .function_address_reg, .descPtr, .irqPending);
  ucz_host_model usbHost (.clk, .hsValid, .hsCode, .txValid, .txData, .txLast,
    .txZlp, .txData1, .tokValid, .tokType, .tokAddr, .tokEndp, .rxValid, .rxData,
    .rxEnd, .rxOk, .hostAck, .txReady);
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  task automatic check(input logic [31:0] s, input logic [31:0] x);
    n_compared++;
    if (s !== x) begin
      mismatches++;
      $display("mismatch at %0t seen %h expected %h", $time, s, x);
    end
  endtask : check
  task automatic give_verdict;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : give_verdict
  // The request stays put until pready is seen high at a rising edge.
  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rv = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(a, 1'b1, d);
  endtask : wr
  task automatic rd(input logic [11:0] a, input logic [31:0] x);
    apb(a, 1'b0, 32'h0);
    check(rv, x);
  endtask : rd
  task automatic hsis(input logic [1:0] x);
    usbHost.hs(hc, got);
    check(32'(hc), 32'(x));
  endtask : hsis
  initial begin
    repeat (5000) @(posedge clk);
    mismatches++;
    give_verdict();
  end
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    foreach (rows[i]) begin
      apb(rows[i].a, 1'b0, 32'h0);
      if (!rows[i].e) check(rv, rows[i].v);
      check(32'(er), 32'(rows[i].e));
    end
    usbHost.tok(TOK_SETUP, 7'h00, 4'h1);
    rd(ADDR_IRQ_REQ, 32'h0);
    usbHost.tok(TOK_SETUP, 7'h00, 4'h0);
    rd(ADDR_IRQ_REQ, 32'h1);
    wr(ADDR_IRQ_EN, 32'h1);
    repeat (2) @(posedge clk);
    check(32'(irqPending), 32'h1);
    wr(ADDR_IRQ_EN, 32'h0);
    wr(ADDR_IRQ_REQ, 32'h1);
    rd(ADDR_IRQ_REQ, 32'h0);
    usbHost.pkt(64'h0002_0000_0000_0080, 8, 1'b0);
    usbHost.hs(hc, got);
    check(32'(got), 32'h0);
    rd(ADDR_IRQ_REQ, 32'h0);
    usbHost.tok(TOK_SETUP, 7'h00, 4'h0);
    usbHost.pkt(64'h0002_0000_0000_0080, 8, 1'b1);
    hsis(HS_ACK);
    rd(ADDR_IRQ_REQ, 32'h3);
    rd(ADDR_CTRL, 32'h6);
    rd(ADDR_SETUP_BASE, 32'h0000_0080);
    rd(ADDR_SETUP_BASE + 12'h004, 32'h0002_0000);
    wr(ADDR_IRQ_REQ, 32'hF);
    wr(ADDR_DATA_BASE, 32'h0000_A55A);
    usbHost.tok(TOK_IN, 7'h00, 4'h0);
    hsis(HS_NAK);
    // Loading a byte count of two, matching the setup length field, arms the data stage.
    wr(ADDR_BYTE_CNT, 32'h2);
    usbHost.slow = 1'b1;
    usbHost.tok(TOK_IN, 7'h00, 4'h0);
    usbHost.rx_in(dq, nb, d1);
    usbHost.slow = 1'b0;
    check(dq[31:0], 32'h0000_A55A);
    check(32'(nb), 32'h2);
    rd(ADDR_IRQ_REQ, 32'h4);
    usbHost.tok(TOK_OUT, 7'h00, 4'h0);
    hsis(HS_NAK);
    usbHost.pkt(64'h0, 0, 1'b1);
    wr(ADDR_CTRL, 32'h6);
    rd(ADDR_CTRL, 32'h4);
    usbHost.tok(TOK_OUT, 7'h00, 4'h0);
    usbHost.pkt(64'h0, 0, 1'b1);
    hsis(HS_ACK);
    usbHost.tok(TOK_SETUP, 7'h00, 4'h0);
    usbHost.pkt(64'h0012_0000_0100_0680, 8, 1'b1);
    hsis(HS_ACK);
    wr(ADDR_CTRL, 32'h5);
    usbHost.tok(TOK_IN, 7'h00, 4'h0);
    hsis(HS_STALL);
    usbHost.tok(TOK_OUT, 7'h00, 4'h0);
    hsis(HS_STALL);
    usbHost.pkt(64'h0, 0, 1'b1);
    wr(ADDR_IRQ_REQ, 32'hF);
    usbHost.tok(TOK_SETUP, 7'h00, 4'h0);
    rd(ADDR_CTRL, 32'h6);
    usbHost.pkt(64'h0000_0000_0012_0500, 8, 1'b1);
    hsis(HS_ACK);
    rd(ADDR_IRQ_REQ, 32'h1);
    rd(ADDR_CTRL, 32'h4);
    rd(ADDR_SETUP_BASE, 32'h0012_0500);
    usbHost.tok(TOK_IN, 7'h00, 4'h0);
    usbHost.rx_in(dq, nb, d1);
    check(32'(nb), 32'h0);
    check(32'(d1), 32'h1);
    repeat (2) @(posedge clk);
    check(32'(function_address_reg), 32'h12);
    usbHost.tok(TOK_SETUP, 7'h12, 4'h0);
    usbHost.pkt(64'h0002_0000_0000_0140, 8, 1'b1);
    hsis(HS_ACK);
    usbHost.tok(TOK_OUT, 7'h12, 4'h0);
    hsis(HS_NAK);
    usbHost.pkt(64'h0066_5544, 3, 1'b1);
    wr(ADDR_BYTE_CNT, 32'h4);
    usbHost.tok(TOK_OUT, 7'h12, 4'h0);
    usbHost.pkt(64'h0033_2211, 3, 1'b1);
    hsis(HS_ACK);
    rd(ADDR_BYTE_CNT, 32'h3);
    rd(ADDR_DATA_BASE, 32'h0033_2211);
    rd(ADDR_IRQ_REQ, 32'hB);
    usbHost.tok(TOK_IN, 7'h12, 4'h0);
    hsis(HS_NAK);
    wr(ADDR_DESC_PTR, 32'h0000_BEEF);
    rd(ADDR_DESC_PTR, 32'h0000_BEEF);
    check(32'(descPtr), 32'h0000_BEEF);
    give_verdict();
  end
endmodule : tb
`default_nettype wire

// *** dv/ucz_host_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module ucz_host_model import ucz_pkg::*; (
  // Clock.
  input wire logic clk,
  // Answers from the device.
  input wire logic hsValid,
  input wire logic [1:0] hsCode,
  input wire logic txValid,
  input wire logic [7:0] txData,
  input wire logic txLast,
  input wire logic txZlp,
  input wire logic txData1,
  // Host traffic.
  output logic tokValid,
  output logic [1:0] tokType,
  output logic [6:0] tokAddr,
  output logic [3:0] tokEndp,
  output logic rxValid,
  output logic [7:0] rxData,
  output logic rxEnd,
  output logic rxOk,
  output logic hostAck,
  output logic txReady
);
  logic slow;
  initial begin
    slow = 1'b0;
    tokValid = 1'b0;
    tokType = 2'h3;
    tokAddr = 7'h7F;
    tokEndp = 4'hF;
    rxValid = 1'b0;
    rxData = 8'h00;
    rxEnd = 1'b0;
    rxOk = 1'b0;
    hostAck = 1'b0;
    txReady = 1'b1;
  end
  //////////////////////////////////////////////////////////////////////////////
  // A slow host is ready only every other cycle, so the device must hold its data.
  always @(posedge clk) txReady <= slow ? ~txReady : 1'b1;
  task automatic tok(input logic [1:0] t, input logic [6:0] a, input logic [3:0] e);
    @(posedge clk);
    tokValid <= 1'b1;
    tokType <= t;
    tokAddr <= a;
    tokEndp <= e;
    @(posedge clk);
    tokValid <= 1'b0;
    tokAddr <= ~a;
    tokEndp <= ~e;
  endtask : tok
  // Idle data lines carry the inverse of the last byte, never a stale copy.
  task automatic pkt(input logic [63:0] d, input int n, input logic ok);
    for (int i = 0; i < n; i++) begin
      @(posedge clk);
      rxValid <= 1'b1;
      rxData <= d[8*i+:8];
    end
    @(posedge clk);
    rxValid <= 1'b0;
    rxData <= ~rxData;
    rxEnd <= 1'b1;
    rxOk <= ok;
    @(posedge clk);
    rxEnd <= 1'b0;
  endtask : pkt
  task automatic hs(output logic [1:0] c, output logic g);
    g = 1'b0;
    c = 2'h3;
    for (int i = 0; i < 20 && !g; i++) begin
      @(posedge clk);
      if (hsValid === 1'b1) begin
        g = 1'b1;
        c = hsCode;
      end
    end
  endtask : hs
  // A zero-length packet counts no bytes; only its PID is kept.
  task automatic rx_in(output logic [63:0] d, output int n, output logic d1);
    logic fin;
    fin = 1'b0;
    n = 0;
    d = 64'h0;
    d1 = 1'b0;
    for (int i = 0; i < 200 && !fin; i++) begin
      @(posedge clk);
      if (txValid === 1'b1 && txReady === 1'b1) begin
        if (txZlp !== 1'b1 && n < 8) d[8*n+:8] = txData;
        if (txZlp !== 1'b1) n++;
        d1 = txData1;
        fin = txLast;
      end
    end
    @(posedge clk);
    hostAck <= 1'b1;
    @(posedge clk);
    hostAck <= 1'b0;
  endtask : rx_in
endmodule : ucz_host_model
`default_nettype wire

// *** src/ucz_byte_store.sv ***
`timescale 1ns/1ps
`default_nettype none
module ucz_byte_store import ucz_pkg::*; #(
  parameter int DEPTH = 8
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // Byte write from the link side.
  input wire logic usbWrEn,
  input wire logic [$clog2(DEPTH)-1:0] usbIdx,
  input wire logic [7:0] usbData,
  // Word write from the register bus.
  input wire logic busWrEn,
  input wire logic [$clog2(DEPTH)-3:0] busWordIdx,
  input wire logic [31:0] busWData,
  // Whole contents.
  output logic [DEPTH*8-1:0] bytes
);
  localparam int IW = $clog2(DEPTH);
  localparam int WW = IW - 2;

  ////////////////////////////////////////////////////////////////////////////////
  // The link write wins a collision, since a packet cannot be paused.
  for (genvar i = 0; i < DEPTH; i++) begin : g_byte
    always_ff @(posedge clk) begin
      if (!rst_n) begin
        bytes[i*8 +: 8] <= 8'h00;
      end else if (usbWrEn && usbIdx == IW'(i)) begin
        bytes[i*8 +: 8] <= usbData;
      end else if (busWrEn && busWordIdx == WW'(i / 4)) begin
        bytes[i*8 +: 8] <= busWData[(i % 4)*8 +: 8];
      end
    end
  end
endmodule : ucz_byte_store
`default_nettype wire

// *** src/ucz_ep0.sv ***
// Summary of operation
// - One shared 64-byte buffer for data stages.
// - Separate 8-byte store holds setup bytes.
// - Only endpoint zero accepts setup tokens.
// - Control endpoint is always enabled.
// - Status is zero-length DATA1, opposite direction.
// - Data packets need a loaded byte count.
// - Hold bit set: status tokens get NAK.
// - Writing one clears hold; status then ACKed.
// - Stall needs both stall and hold bits.
// - New setup token clears the stall bit.
// - Setup token flag set on token.
// - Setup data flag after eight good bytes, except for Set Address.
// - Bad setup data: silent, host retries.
// - Flags sticky until written one, always readable.
// - Enables and requests in separate registers.
// - Setup always accepted, store always overwritten.
// - 16-bit descriptor pointer for IN data.
// - Separate flags per phase, per IN packet.
// - Set Address handled in hardware alone.
`timescale 1ns/1ps
`default_nettype none
module ucz_ep0 import ucz_pkg::*; (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // APB slave.
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Tokens from the serial engine.
  input wire logic tokValid,
  input wire logic [1:0] tokType,
  input wire logic [6:0] tokAddr,
  input wire logic [3:0] tokEndp,
  // Received data packet.
  input wire logic rxValid,
  input wire logic [7:0] rxData,
  input wire logic rxEnd,
  input wire logic rxOk,
  // Host handshake after an IN packet.
  input wire logic hostAck,
  // Handshake to send.
  output logic hsValid,
  output logic [1:0] hsCode,
  // Data packet to send.
  output logic txValid,
  output logic [7:0] txData,
  output logic txLast,
  output logic txZlp,
  output logic txData1,
  input wire logic txReady,
  // Device state.
  output logic [6:0] function_address_reg,
  output logic [15:0] descPtr,
  output logic irqPending
);
  function automatic logic isDataWord(input logic [11:0] a);
    isDataWord = a[11:6] == ADDR_DATA_BASE[11:6] && a[1:0] == 2'h0;
  endfunction : isDataWord

  function automatic logic isSetupWord(input logic [11:0] a);
    isSetupWord = a[11:3] == ADDR_SETUP_BASE[11:3] && a[1:0] == 2'h0;
  endfunction : isSetupWord

  ucz_state_t state_q;
  logic [6:0] idx_q, count_q, pendAddr_q, function_address_reg_q;
  logic [1:0] hsCode_q;
  logic [3:0] irqEn_q, irqReq_q, irqSet;
  logic [15:0] descPtr_q;
  logic [31:0] prdata_q, rdData;
  logic [63:0] setupBytes;
  logic [511:0] dataBytes;
  logic hsValid_q, zlp_q, status_q, stall_q, hold_q, own_q, armed_q, toggle_q, dirIn_q;
  logic hasData_q, pendValid_q, irqPending_q, pslverr_q, rdErr, ep0Hit, setupTok, inTok;
  logic outTok, statusIsIn, stallNow, setupGood, setAddr, outDone, inDone, apbWr, wrCtrl;
  logic wrIrqEn, wrIrqReq, wrCount;

  ////////////////////////////////////////////////////////////////////////////////
  // Token classification.
  ucz_token_match u_match (
    .tokValid(tokValid),
    .tokAddr(tokAddr),
    .tokEndp(tokEndp),
    .function_address_reg(function_address_reg_q),
    .ep0Hit(ep0Hit)
  );

  assign setupTok = ep0Hit && tokType == TOK_SETUP;
  assign inTok = ep0Hit && tokType == TOK_IN;
  assign outTok = ep0Hit && tokType == TOK_OUT;
  // Status runs opposite to the data stage, or IN when there is none.
  assign statusIsIn = !(hasData_q && dirIn_q);
  assign stallNow = stall_q && hold_q;
  assign setupGood = state_q == S_SETUP && rxEnd && rxOk && idx_q == SETUP_COUNT;
  assign setAddr = own_q && setupBytes[7:0] == REQTYPE_STD_DEV_OUT
      && setupBytes[15:8] == REQ_SET_ADDRESS;
  assign outDone = state_q == S_RX && rxEnd && rxOk;
  assign inDone = state_q == S_WAIT && hostAck;

  ////////////////////////////////////////////////////////////////////////////////
  // Storage.
  ucz_byte_store #(.DEPTH(SETUP_BYTES)) u_setup (
    .clk(clk),
    .rst_n(rst_n),
    .usbWrEn(state_q == S_SETUP && rxValid && idx_q < SETUP_COUNT),
    .usbIdx(idx_q[2:0]),
    .usbData(rxData),
    .busWrEn(1'b0),
    .busWordIdx(1'b0),
    .busWData(32'h0000_0000),
    .bytes(setupBytes)
  );

  ucz_byte_store #(.DEPTH(DATA_BYTES)) u_data (
    .clk(clk),
    .rst_n(rst_n),
    .usbWrEn(state_q == S_RX && rxValid && !status_q && idx_q < count_q),
    .usbIdx(idx_q[5:0]),
    .usbData(rxData),
    .busWrEn(apbWr && isDataWord(paddr)),
    .busWordIdx(paddr[5:2]),
    .busWData(pwdata),
    .bytes(dataBytes)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Transaction sequencer.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_q <= S_IDLE;
      idx_q <= 7'h00;
      hsValid_q <= 1'b0;
      hsCode_q <= HS_ACK;
      zlp_q <= 1'b0;
      status_q <= 1'b0;
    end else begin
      hsValid_q <= 1'b0;
      if (setupTok) begin
        // A setup token is never refused and aborts whatever was running.
        state_q <= S_SETUP;
        idx_q <= 7'h00;
      end else begin
        case (state_q)
          S_IDLE: begin
            if (inTok) begin
              status_q <= statusIsIn;
              if (stallNow) begin
                hsValid_q <= 1'b1;
                hsCode_q <= HS_STALL;
              end else if (statusIsIn ? hold_q : !armed_q) begin
                hsValid_q <= 1'b1;
                hsCode_q <= HS_NAK;
              end else begin
                state_q <= S_TX;
                idx_q <= 7'h00;
                zlp_q <= statusIsIn || count_q == 7'h00;
              end
            end else if (outTok) begin
              status_q <= !statusIsIn;
              if (stallNow) begin
                state_q <= S_DROP;
                hsValid_q <= 1'b1;
                hsCode_q <= HS_STALL;
              end else if (!statusIsIn ? hold_q : !armed_q) begin
                state_q <= S_DROP;
                hsValid_q <= 1'b1;
                hsCode_q <= HS_NAK;
              end else begin
                state_q <= S_RX;
                idx_q <= 7'h00;
              end
            end
          end
          S_SETUP: begin
            if (rxValid && idx_q < SETUP_COUNT) begin
              idx_q <= idx_q + 7'h01;
            end
            if (rxEnd) begin
              // A damaged copy gets no handshake, so the host resends it.
              state_q <= S_IDLE;
              hsValid_q <= setupGood;
              hsCode_q <= HS_ACK;
            end
          end
          S_RX: begin
            if (rxValid && idx_q < count_q) begin
              idx_q <= idx_q + 7'h01;
            end
            if (rxEnd) begin
              state_q <= S_IDLE;
              hsValid_q <= rxOk;
              hsCode_q <= HS_ACK;
            end
          end
          S_DROP: begin
            if (rxEnd) begin
              state_q <= S_IDLE;
            end
          end
          S_TX: begin
            if (txReady && txLast) begin
              state_q <= S_WAIT;
            end else if (txReady) begin
              idx_q <= idx_q + 7'h01;
            end
          end
          S_WAIT: begin
            // A fresh token means the host lost our packet; it will retry.
            if (hostAck || tokValid) begin
              state_q <= S_IDLE;
            end
          end
          default: state_q <= S_IDLE;
        endcase
      end
    end
  end

  assign hsValid = hsValid_q;
  assign hsCode = hsCode_q;
  assign txValid = state_q == S_TX;
  assign txData = dataBytes[{idx_q[5:0], 3'h0} +: 8];
  assign txLast = zlp_q || idx_q == count_q - 7'h01;
  assign txZlp = zlp_q;
  assign txData1 = status_q || toggle_q;

  ////////////////////////////////////////////////////////////////////////////////
  // Transfer context captured from the setup packet.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      dirIn_q <= 1'b0;
      hasData_q <= 1'b0;
      toggle_q <= 1'b1;
      pendAddr_q <= FN_ADDR_RESET;
      pendValid_q <= 1'b0;
      function_address_reg_q <= FN_ADDR_RESET;
    end else begin
      if (setupGood) begin
        dirIn_q <= setupBytes[7];
        hasData_q <= setupBytes[63:48] != 16'h0000;
        toggle_q <= 1'b1;
        pendAddr_q <= setupBytes[22:16];
        pendValid_q <= setAddr;
      end else if ((inDone || outDone) && !status_q) begin
        toggle_q <= !toggle_q;
      end else if ((inDone || outDone) && status_q && pendValid_q) begin
        // The new address applies only once the status stage is done.
        function_address_reg_q <= pendAddr_q;
        pendValid_q <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // APB slave.
  assign apbWr = psel && penable && pwrite;
  assign wrCtrl = apbWr && paddr == ADDR_CTRL;
  assign wrIrqEn = apbWr && paddr == ADDR_IRQ_EN;
  assign wrIrqReq = apbWr && paddr == ADDR_IRQ_REQ;
  assign wrCount = apbWr && paddr == ADDR_BYTE_CNT;

  always_comb begin
    rdErr = 1'b0;
    rdData = 32'h0000_0000;
    if (isDataWord(paddr)) begin
      rdData = dataBytes[{paddr[5:2], 5'h00} +: 32];
    end else if (isSetupWord(paddr)) begin
      rdData = setupBytes[{paddr[2], 5'h00} +: 32];
    end else begin
      case (paddr)
        ADDR_CTRL: rdData = {29'h0, own_q, hold_q, stall_q};
        ADDR_IRQ_EN: rdData = {28'h000_0000, irqEn_q};
        ADDR_IRQ_REQ: rdData = {28'h000_0000, irqReq_q};
        ADDR_BYTE_CNT: rdData = {23'h0, armed_q, 1'b0, count_q};
        ADDR_DESC_PTR: rdData = {16'h0000, descPtr_q};
        ADDR_FN_ADDR: rdData = {25'h0, function_address_reg_q};
        default: rdErr = 1'b1;
      endcase
    end
  end

  // Read data is caught in the setup cycle so the access needs no wait state.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      prdata_q <= 32'h0000_0000;
      pslverr_q <= 1'b0;
    end else if (psel && !penable) begin
      prdata_q <= rdData;
      pslverr_q <= rdErr;
    end
  end

  assign prdata = prdata_q;
  assign pready = 1'b1;
  assign pslverr = pslverr_q && psel && penable;

  ////////////////////////////////////////////////////////////////////////////////
  // Control bits.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      stall_q <= 1'b0;
      hold_q <= 1'b0;
      own_q <= OWN_RESET;
    end else begin
      // Firmware setting stall in the token cycle wins over the auto clear.
      if (wrCtrl) begin
        stall_q <= pwdata[CTRL_STALL_BIT];
      end else if (setupTok) begin
        stall_q <= 1'b0;
      end
      if (setupGood && !setAddr) begin
        hold_q <= 1'b1;
      end else if (setupGood || (wrCtrl && pwdata[CTRL_HOLD_BIT])) begin
        hold_q <= 1'b0;
      end
      if (wrCtrl) begin
        own_q <= pwdata[CTRL_OWN_BIT];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Interrupt enables and sticky requests.
  always_comb begin
    irqSet = 4'h0;
    irqSet[IRQ_SETUP_TOKEN_IRQ_BIT] = setupTok;
    irqSet[IRQ_SETUP_DATA_READY_IRQ_BIT] = setupGood && !setAddr;
    irqSet[IRQ_IN_BIT] = inDone && !status_q;
    irqSet[IRQ_OUT_BIT] = outDone && !status_q;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      irqEn_q <= IRQ_EN_RESET;
      irqReq_q <= 4'h0;
      irqPending_q <= 1'b0;
    end else begin
      if (wrIrqEn) begin
        irqEn_q <= pwdata[3:0];
      end
      // New events win over a write-one clear in the same cycle.
      irqReq_q <= (irqReq_q & ~(wrIrqReq ? pwdata[3:0] : 4'h0)) | irqSet;
      irqPending_q <= |(irqReq_q & irqEn_q);
    end
  end

  assign irqPending = irqPending_q;

  ////////////////////////////////////////////////////////////////////////////////
  // Byte count and descriptor pointer.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      armed_q <= 1'b0;
      count_q <= 7'h00;
      descPtr_q <= DESC_PTR_RESET;
    end else begin
      if (wrCount) begin
        // Loading the count arms one data packet; a zero count sends a zero-length packet.
        armed_q <= 1'b1;
        count_q <= (pwdata[6:0] > MAX_COUNT) ? MAX_COUNT : pwdata[6:0];
      end else if (setupTok || ((inDone || outDone) && !status_q)) begin
        armed_q <= 1'b0;
        if (outDone) begin
          count_q <= idx_q;
        end
      end
      if (apbWr && paddr == ADDR_DESC_PTR) begin
        descPtr_q <= pwdata[15:0];
      end
    end
  end

  assign function_address_reg = function_address_reg_q;
  assign descPtr = descPtr_q;

  ////////////////////////////////////////////////////////////////////////////////
  // Checks.
  a_setup_token_irq_on_token: assert property (
    @(posedge clk) disable iff (!rst_n) setupTok |=> irqReq_q[IRQ_SETUP_TOKEN_IRQ_BIT])
    else $error("Setup token flag not raised after setup token.");

  a_setup_not_refused: assert property (
    @(posedge clk) disable iff (!rst_n)
    setupTok |=> state_q == S_SETUP && !(hsValid && hsCode != HS_ACK))
    else $error("Setup token was refused.");

  a_stall_cleared_setup: assert property (
    @(posedge clk) disable iff (!rst_n) setupTok && !wrCtrl |=> !stall_q)
    else $error("Stall bit survived a new setup token.");

  a_setup_data_ready_irq_after_good: assert property (
    @(posedge clk) disable iff (!rst_n)
    !irqReq_q[IRQ_SETUP_DATA_READY_IRQ_BIT] ##1 irqReq_q[IRQ_SETUP_DATA_READY_IRQ_BIT] |-> $past(setupGood))
    else $error("Setup data flag rose without a good setup packet.");

  a_nak_unarmed: assert property (
    @(posedge clk) disable iff (!rst_n)
    state_q == S_IDLE && inTok && !statusIsIn && !stallNow && !armed_q
    |=> hsValid && hsCode == HS_NAK && state_q == S_IDLE)
    else $error("Data IN not refused while byte count unloaded.");

  a_hold_naks_status: assert property (
    @(posedge clk) disable iff (!rst_n)
    state_q == S_IDLE && inTok && statusIsIn && hold_q && !stall_q
    |=> hsValid && hsCode == HS_NAK)
    else $error("Status token not answered with NAK while held.");

  a_stall_needs_both: assert property (
    @(posedge clk) disable iff (!rst_n)
    hsValid && hsCode == HS_STALL |-> $past(stall_q) && $past(hold_q))
    else $error("Stall sent without both stall and hold set.");

  a_hold_after_setup: assert property (
    @(posedge clk) disable iff (!rst_n) setupGood && !setAddr |=> hold_q [*2])
    else $error("Hold bit not set after a good setup packet.");
endmodule : ucz_ep0
`default_nettype wire

// *** src/ucz_pkg.sv ***
`default_nettype none
package ucz_pkg;
  // Buffer sizes.
  localparam int DATA_BYTES = 64;
  localparam int SETUP_BYTES = 8;
  localparam logic [6:0] MAX_COUNT = 7'h40;
  localparam logic [6:0] SETUP_COUNT = 7'h08;

  // Register byte addresses.
  localparam logic [11:0] ADDR_CTRL = 12'h000;
  localparam logic [11:0] ADDR_IRQ_EN = 12'h004;
  localparam logic [11:0] ADDR_IRQ_REQ = 12'h008;
  localparam logic [11:0] ADDR_BYTE_CNT = 12'h00C;
  localparam logic [11:0] ADDR_DESC_PTR = 12'h010;
  localparam logic [11:0] ADDR_FN_ADDR = 12'h014;
  localparam logic [11:0] ADDR_SETUP_BASE = 12'h020;
  localparam logic [11:0] ADDR_DATA_BASE = 12'h040;

  // Field positions.
  localparam int CTRL_STALL_BIT = 0;
  localparam int CTRL_HOLD_BIT = 1;
  localparam int CTRL_OWN_BIT = 2;
  localparam int IRQ_SETUP_TOKEN_IRQ_BIT = 0;
  localparam int IRQ_SETUP_DATA_READY_IRQ_BIT = 1;
  localparam int IRQ_IN_BIT = 2;
  localparam int IRQ_OUT_BIT = 3;
  localparam int BC_BUSY_BIT = 8;

  // Reset values.
  localparam logic OWN_RESET = 1'b1;
  localparam logic [3:0] IRQ_EN_RESET = 4'h0;
  localparam logic [15:0] DESC_PTR_RESET = 16'h0000;
  localparam logic [6:0] FN_ADDR_RESET = 7'h00;

  // Token kinds from the serial engine and handshakes back to it.
  localparam logic [1:0] TOK_OUT = 2'h0;
  localparam logic [1:0] TOK_IN = 2'h1;
  localparam logic [1:0] TOK_SETUP = 2'h2;
  localparam logic [1:0] HS_ACK = 2'h0;
  localparam logic [1:0] HS_NAK = 2'h1;
  localparam logic [1:0] HS_STALL = 2'h2;

  // Request fields handled in hardware.
  localparam logic [7:0] REQTYPE_STD_DEV_OUT = 8'h00;
  localparam logic [7:0] REQ_SET_ADDRESS = 8'h05;

  typedef enum logic [2:0] {
    S_IDLE, S_SETUP, S_RX, S_DROP, S_TX, S_WAIT
  } ucz_state_t;
endpackage : ucz_pkg
`default_nettype wire

// *** src/ucz_token_match.sv ***
`timescale 1ns/1ps
`default_nettype none
module ucz_token_match import ucz_pkg::*; (
  // Token from the serial engine.
  input wire logic tokValid,
  input wire logic [6:0] tokAddr,
  input wire logic [3:0] tokEndp,
  // Current function address.
  input wire logic [6:0] function_address_reg,
  // Token is for the control endpoint.
  output logic ep0Hit
);
  ////////////////////////////////////////////////////////////////////////////////
  // Endpoint zero has no enable term, so it always answers the host.
  assign ep0Hit = tokValid && tokEndp == 4'h0 && tokAddr == function_address_reg;
endmodule : ucz_token_match
`default_nettype wire
